// file: dtp_pkg.sv
// Shared constants, field layouts and carrier types for the dual timer pair.
`default_nettype none
package dtp_pkg;

	// Width of one timer word.
	localparam int DTP_DW = 16;

	// Wishbone byte offsets of the registers.
	localparam logic [7:0] DTP_OFS_LOW_COUNT = 8'h00;
	localparam logic [7:0] DTP_OFS_HOLDING = 8'h04;
	localparam logic [7:0] DTP_OFS_HIGH_COUNT = 8'h08;
	localparam logic [7:0] DTP_OFS_PERIOD_LOW = 8'h0c;
	localparam logic [7:0] DTP_OFS_PERIOD_HIGH = 8'h10;
	localparam logic [7:0] DTP_OFS_LOW_CTRL = 8'h14;
	localparam logic [7:0] DTP_OFS_HIGH_CTRL = 8'h18;
	localparam logic [7:0] DTP_OFS_FLAGS = 8'h1c;
	localparam logic [7:0] DTP_OFS_IRQ_EN = 8'h20;

	// Field positions inside a timer control register.
	localparam int DTP_BIT_RUN = 15;
	localparam int DTP_BIT_IDLE_STOP = 13;
	localparam int DTP_BIT_GATE = 6;
	localparam int DTP_BIT_PSC_HI = 5;
	localparam int DTP_BIT_PSC_LO = 4;
	localparam int DTP_BIT_COMBINE = 3;
	localparam int DTP_BIT_CLK_SRC = 1;

	// Writable bits of each control register; the rest read as zero.
	localparam logic [15:0] DTP_LOW_CTRL_MASK = 16'ha07a;
	localparam logic [15:0] DTP_HIGH_CTRL_MASK = 16'ha072;

	// Values after reset.
	localparam logic [15:0] DTP_RST_COUNT = 16'h0000;
	localparam logic [15:0] DTP_RST_PERIOD = 16'hffff;
	localparam logic [15:0] DTP_RST_CTRL = 16'h0000;

	// Instruction cycle is the reference clock divided by four.
	localparam int DTP_REF_CLK_HZ = 100000000;
	localparam int DTP_TCY_DIV = 4;
	localparam logic [1:0] DTP_TCY_LAST = 2'(DTP_TCY_DIV - 1);

	// Prescaler terminal counts for divide by 1, 8, 64 and 256.
	localparam logic [7:0] DTP_PSC_TERM_1 = 8'h00;
	localparam logic [7:0] DTP_PSC_TERM_8 = 8'h07;
	localparam logic [7:0] DTP_PSC_TERM_64 = 8'h3f;
	localparam logic [7:0] DTP_PSC_TERM_256 = 8'hff;

	// Decoded fields of one control register.
	typedef struct packed {
		logic run;
		logic idle_stop;
		logic gate;
		logic [1:0] prescale_select;
		logic combine;
		logic clock_source_select;
	} dtp_ctrl_t;

	// Unpacks a control word into its fields.
	function automatic dtp_ctrl_t dtp_decode(input logic [15:0] r);
		dtp_ctrl_t c;
		c.run = r[DTP_BIT_RUN];
		c.idle_stop = r[DTP_BIT_IDLE_STOP];
		c.gate = r[DTP_BIT_GATE];
		c.prescale_select = r[DTP_BIT_PSC_HI:DTP_BIT_PSC_LO];
		c.combine = r[DTP_BIT_COMBINE];
		c.clock_source_select = r[DTP_BIT_CLK_SRC];
		return c;
	endfunction : dtp_decode

	// Merges write data into a 16-bit register under byte selects.
	function automatic logic [15:0] dtp_merge(input logic [15:0] old, input logic [15:0] dat,
			input logic [1:0] sel);
		logic [15:0] m;
		m = {{8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (dat & m);
	endfunction : dtp_merge

endpackage : dtp_pkg
`default_nettype wire

// file: dtp_sync.sv
// Two flip-flop synchroniser for pin levels.
`timescale 1ns/10ps
`default_nettype none
module dtp_sync #(
	parameter int W = 2
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Level in and synchronised level out.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	// First stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule : dtp_sync
`default_nettype wire

// file: dtp_prescaler.sv
// Clock prescaler dividing a source tick by 1, 8, 64 or 256.
`timescale 1ns/10ps
`default_nettype none
module dtp_prescaler
	import dtp_pkg::*;
#(
	parameter bit SYNC_OUT = 1'b0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Control.
	input wire logic run,
	input wire logic advance,
	input wire logic clear,
	input wire logic [1:0] prescale_select,
	// Source tick in, divided tick out.
	input wire logic src_tick,
	output logic tick
);

	logic [7:0] cnt_r;
	logic [7:0] term;
	logic at_term;
	logic raw_tick;

	// Terminal count from the select field.
	always_comb begin
		case (prescale_select)
			2'h0: term = DTP_PSC_TERM_1;
			2'h1: term = DTP_PSC_TERM_8;
			2'h2: term = DTP_PSC_TERM_64;
			2'h3: term = DTP_PSC_TERM_256;
			default: term = DTP_PSC_TERM_1;
		endcase
	end

	assign at_term = (cnt_r >= term);
	assign raw_tick = advance & src_tick & at_term & ~clear;

	// A stopped prescaler keeps its count, so a clear has no effect then.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
		end else if (run && clear) begin
			cnt_r <= 8'h00;
		end else if (advance && src_tick) begin
			cnt_r <= at_term ? 8'h00 : cnt_r + 8'h01;
		end
	end

	// Optional output register that retimes the tick onto the clock.
	generate
		if (SYNC_OUT) begin : g_sync
			logic tick_r;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					tick_r <= 1'b0;
				end else begin
					tick_r <= raw_tick;
				end
			end
			assign tick = tick_r;
		end else begin : g_direct
			assign tick = raw_tick;
		end
	endgenerate

endmodule : dtp_prescaler
`default_nettype wire

// file: dtp_top.sv
// Dual 16-bit timer pair with a 32-bit combined mode behind a Wishbone slave.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module dtp_top
	import dtp_pkg::*;
(
	// Clock and asynchronous reset.
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// Wishbone slave.
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Pins: clock or gate for the low timer, clock or gate for the high timer.
	input wire logic GATE_CLOCK_PIN,
	input wire logic HIGH_CLOCK_PIN,
	// CPU power state.
	input wire logic CPU_IDLE,
	input wire logic CPU_SLEEP,
	// Events.
	output logic LOW_IRQ,
	output logic MATCH_IRQ,
	output logic ADC_TRIG
);

	// Reset release pipeline.
	logic [1:0] rst_pipe_r;
	logic rst_n;

	// Instruction cycle divider.
	logic [1:0] tcy_cnt_r;
	logic tcy_en;

	// Pin sampling.
	logic [1:0] pin_s;
	logic [1:0] pin_prev_r;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;

	// Register file.
	logic [15:0] cnt_r [2];
	logic [15:0] cnt_nxt [2];
	logic [15:0] per_r [2];
	logic [15:0] ctrl_r [2];
	logic [15:0] high_word_holding_r;
	logic [1:0] flag_r;
	logic [1:0] flag_nxt;
	logic [1:0] irq_en_r;
	logic [1:0] set_v;

	// Bus decode.
	logic ack_r;
	logic acc;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [15:0] wdat;
	logic [1:0] wsel;
	logic wr_low_count;
	logic wr_high_count;
	logic wr_holding;
	logic wr_per_low;
	logic wr_per_high;
	logic wr_low_ctrl;
	logic wr_high_ctrl;
	logic wr_flags;
	logic wr_irq_en;
	logic rd_low_count;
	logic [31:0] rd_nxt;

	// Timer control and ticks.
	logic combine;
	dtp_ctrl_t eff [2];
	logic [1:0] active;
	logic [1:0] src_tick;
	logic [1:0] psc_clear;
	logic [1:0] psc_tick;
	logic [1:0] gate_fall;
	logic [1:0] match16;
	logic match32;
	logic trig_nxt;

	// Reset is released through two flip-flops.
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_r[1];

	// Instruction cycle enable, one pulse every four reference clocks.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tcy_cnt_r <= 2'h0;
		end else begin
			tcy_cnt_r <= tcy_en ? 2'h0 : tcy_cnt_r + 2'h1;
		end
	end
	assign tcy_en = (tcy_cnt_r == DTP_TCY_LAST);

	// Both pins are synchronised before any edge detection.
	dtp_sync #(
		.W(2)
	) u_pin_sync (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.d({HIGH_CLOCK_PIN, GATE_CLOCK_PIN}),
		.q(pin_s)
	);

	// Edge detectors on the synchronised levels.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev_r <= 2'h0;
		end else begin
			pin_prev_r <= pin_s;
		end
	end
	assign pin_rise = pin_s & ~pin_prev_r;
	assign pin_fall = ~pin_s & pin_prev_r;

	// Wishbone decode; each access is answered one cycle after it is seen.
	assign acc = WB_CYC_I & WB_STB_I & ~ack_r;
	assign wr = acc & WB_WE_I;
	assign rd = acc & ~WB_WE_I;
	assign addr = {WB_ADR_I[7:2], 2'b00};
	assign wdat = WB_DAT_I[15:0];
	assign wsel = WB_SEL_I[1:0];
	assign wr_low_count = wr & (addr == DTP_OFS_LOW_COUNT);
	assign wr_holding = wr & (addr == DTP_OFS_HOLDING);
	assign wr_high_count = wr & (addr == DTP_OFS_HIGH_COUNT);
	assign wr_per_low = wr & (addr == DTP_OFS_PERIOD_LOW);
	assign wr_per_high = wr & (addr == DTP_OFS_PERIOD_HIGH);
	assign wr_low_ctrl = wr & (addr == DTP_OFS_LOW_CTRL);
	assign wr_high_ctrl = wr & (addr == DTP_OFS_HIGH_CTRL);
	assign wr_flags = wr & (addr == DTP_OFS_FLAGS);
	assign wr_irq_en = wr & (addr == DTP_OFS_IRQ_EN);
	assign rd_low_count = rd & (addr == DTP_OFS_LOW_COUNT);

	// Combined mode takes every setting from the low control register.
	assign combine = ctrl_r[0][DTP_BIT_COMBINE];
	assign eff[0] = dtp_decode(ctrl_r[0]);
	assign eff[1] = combine ? eff[0] : dtp_decode(ctrl_r[1]);

	// Per-timer clock source, gating and prescaler.
	generate
		for (genvar i = 0; i < 2; i++) begin : g_tmr
			// In combined mode both lanes look at the low timer's pin.
			logic pin_lvl;
			logic pin_up;
			logic pin_down;
			assign pin_lvl = combine ? pin_s[0] : pin_s[i];
			assign pin_up = combine ? pin_rise[0] : pin_rise[i];
			assign pin_down = combine ? pin_fall[0] : pin_fall[i];

			// Counting halts in sleep, and in idle when asked to.
			assign active[i] = eff[i].run & ~CPU_SLEEP & ~(CPU_IDLE & eff[i].idle_stop);

			// External source counts rising pin edges; internal counts Tcy, gated if set.
			assign src_tick[i] = eff[i].clock_source_select ? pin_up
				: (tcy_en & (~eff[i].gate | pin_lvl));

			// Falling gate edge ends an accumulation; the count is kept.
			assign gate_fall[i] = eff[i].run & eff[i].gate & ~eff[i].clock_source_select
				& pin_down;

			// Writes to the timer's count or control clear its prescaler.
			assign psc_clear[i] = (i == 0) ? (wr_low_count | wr_low_ctrl)
				: (wr_high_count | wr_high_ctrl);

			assign match16[i] = (cnt_r[i] == per_r[i]);

			// Only the low lane retimes its output.
			dtp_prescaler #(
				.SYNC_OUT(i == 0)
			) u_psc (
				.clk(REF_CLK),
				.rst_n(rst_n),
				.run(eff[i].run),
				.advance(active[i]),
				.clear(psc_clear[i]),
				.prescale_select(eff[i].prescale_select),
				.src_tick(src_tick[i]),
				.tick(psc_tick[i])
			);
		end
	endgenerate

	// Low word is the low timer, high word the high timer.
	assign match32 = ({cnt_r[1], cnt_r[0]} == {per_r[1], per_r[0]});

	// Trigger pulse toward the converter on a high-side period match.
	assign trig_nxt = combine ? (psc_tick[0] & match32)
		: (psc_tick[1] & match16[1]);

	// Next counts and flag sets; a bus write to a count wins over a tick.
	always_comb begin
		cnt_nxt[0] = cnt_r[0];
		cnt_nxt[1] = cnt_r[1];
		set_v = 2'h0;
		if (combine) begin
			// Only the low prescaler clocks the 32-bit count.
			if (psc_tick[0]) begin
				if (match32) begin
					{cnt_nxt[1], cnt_nxt[0]} = 32'h0000_0000;
					set_v[1] = 1'b1;
				end else begin
					{cnt_nxt[1], cnt_nxt[0]} = {cnt_r[1], cnt_r[0]} + 32'h0000_0001;
				end
			end
			if (gate_fall[0]) begin
				set_v[1] = 1'b1;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (psc_tick[i]) begin
					if (match16[i]) begin
						cnt_nxt[i] = DTP_RST_COUNT;
						set_v[i] = 1'b1;
					end else begin
						cnt_nxt[i] = cnt_r[i] + 16'h0001;
					end
				end
				if (gate_fall[i]) begin
					set_v[i] = 1'b1;
				end
			end
		end
		// Only count writes touch the counts; control writes never do.
		if (wr_low_count) begin
			cnt_nxt[0] = dtp_merge(cnt_r[0], wdat, wsel);
			if (combine) begin
				cnt_nxt[1] = high_word_holding_r;
			end
		end
		if (wr_high_count) begin
			cnt_nxt[1] = dtp_merge(cnt_r[1], wdat, wsel);
		end
	end

	// Flags: hardware sets, software clears by writing one; a set wins.
	assign flag_nxt = (flag_r & ~({2{wr_flags & wsel[0]}} & wdat[1:0]))
		| set_v;

	// Read multiplexer; unmapped offsets read zero.
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (addr)
			DTP_OFS_LOW_COUNT: rd_nxt[15:0] = cnt_r[0];
			DTP_OFS_HOLDING: rd_nxt[15:0] = high_word_holding_r;
			DTP_OFS_HIGH_COUNT: rd_nxt[15:0] = cnt_r[1];
			DTP_OFS_PERIOD_LOW: rd_nxt[15:0] = per_r[0];
			DTP_OFS_PERIOD_HIGH: rd_nxt[15:0] = per_r[1];
			DTP_OFS_LOW_CTRL: rd_nxt[15:0] = ctrl_r[0];
			DTP_OFS_HIGH_CTRL: rd_nxt[15:0] = ctrl_r[1];
			DTP_OFS_FLAGS: rd_nxt[1:0] = flag_r;
			DTP_OFS_IRQ_EN: rd_nxt[1:0] = irq_en_r;
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// Bus answer registers.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			ack_r <= acc;
			WB_DAT_O <= rd ? rd_nxt : 32'h0000_0000;
		end
	end
	assign WB_ACK_O = ack_r;

	// Counts and the holding word.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r[0] <= DTP_RST_COUNT;
			cnt_r[1] <= DTP_RST_COUNT;
			high_word_holding_r <= DTP_RST_COUNT;
		end else begin
			cnt_r[0] <= cnt_nxt[0];
			cnt_r[1] <= cnt_nxt[1];
			if (rd_low_count) begin
				high_word_holding_r <= cnt_r[1];
			end else if (wr_holding) begin
				high_word_holding_r <= dtp_merge(high_word_holding_r, wdat, wsel);
			end
		end
	end

	// Periods and control registers.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			per_r[0] <= DTP_RST_PERIOD;
			per_r[1] <= DTP_RST_PERIOD;
			ctrl_r[0] <= DTP_RST_CTRL;
			ctrl_r[1] <= DTP_RST_CTRL;
		end else begin
			if (wr_per_low) begin
				per_r[0] <= dtp_merge(per_r[0], wdat, wsel);
			end
			if (wr_per_high) begin
				per_r[1] <= dtp_merge(per_r[1], wdat, wsel);
			end
			if (wr_low_ctrl) begin
				ctrl_r[0] <= dtp_merge(ctrl_r[0], wdat, wsel) & DTP_LOW_CTRL_MASK;
			end
			if (wr_high_ctrl) begin
				ctrl_r[1] <= dtp_merge(ctrl_r[1], wdat, wsel) & DTP_HIGH_CTRL_MASK;
			end
		end
	end

	// Flags, enables and the registered event outputs.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= 2'h0;
			irq_en_r <= 2'h0;
			LOW_IRQ <= 1'b0;
			MATCH_IRQ <= 1'b0;
			ADC_TRIG <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			if (wr_irq_en && wsel[0]) begin
				irq_en_r <= wdat[1:0];
			end
			LOW_IRQ <= flag_r[0] & irq_en_r[0];
			MATCH_IRQ <= flag_r[1] & irq_en_r[1];
			ADC_TRIG <= trig_nxt;
		end
	end

endmodule : dtp_top
`default_nettype wire

// file: dtp_top_monitor.sv
// Port checker for the dual timer pair, bound into the top module.
`timescale 1ns/10ps
`default_nettype none
module dtp_top_monitor (
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// Wishbone slave.
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Power state and events.
	input wire logic CPU_SLEEP,
	input wire logic LOW_IRQ,
	input wire logic MATCH_IRQ,
	input wire logic ADC_TRIG
);
	// All checks share the one clock and rest while reset is low.
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	property p_ack_once; WB_ACK_O |=> !WB_ACK_O; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	property p_ack_answer; (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O; endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
	property p_ack_cause; !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O; endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
	property p_rdata_idle; (!WB_ACK_O || WB_WE_I) |-> (WB_DAT_O == 32'h0); endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read ack");
	property p_trig_once; ADC_TRIG |=> !ADC_TRIG; endproperty
	a_trig_once: assert property (p_trig_once) else $error("trigger longer than one cycle");
	property p_sleep_quiet; CPU_SLEEP [*5] |-> !ADC_TRIG; endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("trigger during sleep");
	property p_match_hold;
		$fell(MATCH_IRQ) |-> $past(WB_WE_I && WB_ACK_O) || $past(WB_WE_I && WB_ACK_O, 2);
	endproperty
	a_match_hold: assert property (p_match_hold) else $error("match irq dropped by itself");
	property p_low_hold;
		$fell(LOW_IRQ) |-> $past(WB_WE_I && WB_ACK_O) || $past(WB_WE_I && WB_ACK_O, 2);
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("low irq fell without a write");
endmodule : dtp_top_monitor
bind dtp_top dtp_top_monitor u_mon (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.CPU_SLEEP(CPU_SLEEP), .LOW_IRQ(LOW_IRQ), .MATCH_IRQ(MATCH_IRQ), .ADC_TRIG(ADC_TRIG));
`default_nettype wire

// file: dtp_pin_model.sv
// Far-side source of the clock and gate pins of the timer pair.
`timescale 1ns/10ps
`default_nettype none
module dtp_pin_model (
	// Pin levels toward the timer pair.
	output var logic gate_clock_pin,
	output var logic high_clock_pin
);
	// Both pins rest low between bursts.
	initial begin
		gate_clock_pin = 1'b0;
		high_clock_pin = 1'b0;
	end
	// Pulses one pin n times at a rate unrelated to the bus clock.
	task automatic pulse(input bit hi, input int n);
		for (int i = 0; i < n; i++) begin
			#37.3 {high_clock_pin, gate_clock_pin} = hi ? 2'b10 : 2'b01;
			#37.3 {high_clock_pin, gate_clock_pin} = 2'b00;
		end
	endtask : pulse
	// Holds the gate high for a span, then lets it fall.
	task automatic gate(input int span);
		// Move off the clock edge so the synchroniser never races the pin.
		#3 gate_clock_pin = 1'b1;
		#span gate_clock_pin = 1'b0;
	endtask : gate
endmodule : dtp_pin_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the dual timer pair.
`timescale 1ns/10ps
`default_nettype none
module tb_top import dtp_pkg::*; ();
	typedef struct {string nm; logic [15:0] v; int tol;} dtp_exp_t;
	logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0, sleep = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic ack, low_irq, match_irq, trig, gpin, hpin;
	int failures = 0, tests_run = 0, cyc_n = 0;
	int div_tab[4] = '{1, 8, 64, 256};
	dtp_exp_t expq[$];
	dtp_exp_t e;
	// Clock, design and pin source.
	always #5 clk = ~clk;
	dtp_top u_dut (.REF_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.GATE_CLOCK_PIN(gpin), .HIGH_CLOCK_PIN(hpin), .CPU_IDLE(idle), .CPU_SLEEP(sleep),
		.LOW_IRQ(low_irq), .MATCH_IRQ(match_irq), .ADC_TRIG(trig));
	dtp_pin_model u_pins (.gate_clock_pin(gpin), .high_clock_pin(hpin));
	// Compares a value seen against an expectation with a tolerance.
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp,
			input int tol);
		tests_run++;
		if ((^seen === 1'bx) || (seen > exp + tol) || (seen + tol < exp)) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("Checks run %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	// One classic Wishbone cycle, held until ack is sampled.
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] v, input int tol = 0);
		expq.push_back('{nm, v, tol});
		wb(1'b0, a, 16'h0);
	endtask : rd
	task automatic wait_trig(output int t);
		t = 0;
		do begin @(posedge clk); t++; end while (trig !== 1'b1);
	endtask : wait_trig
	// Takes the oldest expectation whenever read data is acknowledged.
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (expq.size() > 0) e = expq.pop_front();
			else e = '{"unexpected read", 16'hdead, 0};
			check(e.nm, rdat[15:0], e.v, e.tol);
		end
	end
	// Cuts a hang short.
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 30000) begin
			failures++;
			end_of_test();
		end
	end
	// Main sequence.
	initial begin
		int t;
		logic [15:0] hw, lw;
		void'($urandom(32'ha54c9ac8));
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int a = 0; a <= 8'h24; a += 4)
			rd("reset value", 8'(a), (a == 12 || a == 16) ? 16'hffff : 16'h0);
		wr(DTP_OFS_LOW_CTRL, 16'hffff);
		wr(DTP_OFS_HIGH_CTRL, 16'hffff);
		rd("low ctrl", DTP_OFS_LOW_CTRL, DTP_LOW_CTRL_MASK, 0);
		rd("high ctrl", DTP_OFS_HIGH_CTRL, DTP_HIGH_CTRL_MASK, 0);
		rd("count after ctrl", DTP_OFS_LOW_COUNT, 16'h0);
		wr(DTP_OFS_HIGH_CTRL, 16'h0000);
		hw = 16'($urandom());
		lw = 16'($urandom());
		wr(DTP_OFS_LOW_CTRL, 16'h0008);
		wr(DTP_OFS_HOLDING, hw);
		wr(DTP_OFS_LOW_COUNT, lw);
		rd("high count", DTP_OFS_HIGH_COUNT, hw);
		wr(DTP_OFS_HIGH_COUNT, ~hw);
		rd("low count", DTP_OFS_LOW_COUNT, lw);
		rd("holding", DTP_OFS_HOLDING, ~hw);
		wr(DTP_OFS_LOW_CTRL, 16'h0038);
		rd("count kept", DTP_OFS_LOW_COUNT, lw);
		// Zero periods: every tick matches, so trigger spacing is the tick period.
		wr(DTP_OFS_PERIOD_LOW, 16'h0000);
		wr(DTP_OFS_PERIOD_HIGH, 16'h0000);
		wr(DTP_OFS_HOLDING, 16'h0000);
		wr(DTP_OFS_LOW_COUNT, 16'h0000);
		wr(DTP_OFS_IRQ_EN, 16'h0003);
		for (int ps = 0; ps < 4; ps++) begin
			wr(DTP_OFS_LOW_CTRL, 16'h8008 | 16'(ps << 4));
			wait_trig(t);
			wait_trig(t);
			check("trigger spacing", 16'(t), 16'(4 * div_tab[ps]), 0);
		end
		check("match irq", {15'h0, match_irq}, 16'h1, 0);
		wr(DTP_OFS_LOW_CTRL, 16'h0008);
		wr(DTP_OFS_FLAGS, 16'h0003);
		wr(DTP_OFS_PERIOD_LOW, 16'hffff);
		wr(DTP_OFS_PERIOD_HIGH, 16'hffff);
		wr(DTP_OFS_LOW_COUNT, 16'h0000);
		wr(DTP_OFS_LOW_CTRL, 16'h8048);
		u_pins.gate(400);
		repeat (10) @(posedge clk);
		rd("gated count", DTP_OFS_LOW_COUNT, 16'd10, 1);
		repeat (40) @(posedge clk);
		rd("held count", DTP_OFS_LOW_COUNT, 16'd10, 1);
		rd("gate flag", DTP_OFS_FLAGS, 16'h0002);
		// Pin counting: the high pin is ignored while combined.
		wr(DTP_OFS_LOW_COUNT, 16'h0000);
		wr(DTP_OFS_HIGH_CTRL, 16'h8002);
		wr(DTP_OFS_LOW_CTRL, 16'h800a);
		u_pins.pulse(1'b0, 5);
		u_pins.pulse(1'b1, 3);
		repeat (10) @(posedge clk);
		rd("pin count", DTP_OFS_LOW_COUNT, 16'd5);
		rd("ignored high pin", DTP_OFS_HOLDING, 16'd0);
		wr(DTP_OFS_LOW_CTRL, 16'h0000);
		wr(DTP_OFS_HIGH_COUNT, 16'h0000);
		u_pins.pulse(1'b1, 3);
		repeat (10) @(posedge clk);
		rd("split high count", DTP_OFS_HIGH_COUNT, 16'd3);
		// Idle with the stop bit, then sleep, then idle without it.
		wr(DTP_OFS_HIGH_CTRL, 16'h0000);
		wr(DTP_OFS_LOW_COUNT, 16'h0000);
		idle <= 1'b1;
		wr(DTP_OFS_LOW_CTRL, 16'ha008);
		repeat (40) @(posedge clk);
		rd("idle stopped", DTP_OFS_LOW_COUNT, 16'd0);
		sleep <= 1'b1;
		wr(DTP_OFS_LOW_CTRL, 16'h8008);
		repeat (40) @(posedge clk);
		rd("sleep stopped", DTP_OFS_LOW_COUNT, 16'd0);
		sleep <= 1'b0;
		repeat (40) @(posedge clk);
		wr(DTP_OFS_LOW_CTRL, 16'h0008);
		rd("idle running", DTP_OFS_LOW_COUNT, 16'd11, 2);
		idle <= 1'b0;
		// Split low timer match raises its own flag until software clears it.
		wr(DTP_OFS_PERIOD_LOW, 16'h0000);
		wr(DTP_OFS_LOW_COUNT, 16'h0000);
		wr(DTP_OFS_LOW_CTRL, 16'h8000);
		repeat (20) @(posedge clk);
		wr(DTP_OFS_LOW_CTRL, 16'h0000);
		check("low irq", {15'h0, low_irq}, 16'h1, 0);
		wr(DTP_OFS_FLAGS, 16'h0003);
		rd("flags cleared", DTP_OFS_FLAGS, 16'h0000);
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
